// ===== core/rbs_exec.sv
// execution of the relative branch and single-bit set instructions
`timescale 1ns/1ps
`default_nettype none
`include "rbs_map.svh"

// How it works
// (RQ1) branch opcode 11010, 11-bit signed offset
// (RQ2) offset applies to already advanced counter
// (RQ3) target is branch address plus 2 plus 2n
// (RQ4) branch takes two cycles, second flushed
// (RQ5) bit set: read, force bit, write, one cycle
module rbs_exec #(
    parameter int ADDR_W = 21
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst,
    // instruction from fetch; counter already points past it
    input  wire logic                instr_valid,
    input  wire logic [15:0]         instr,
    input  wire logic [ADDR_W-1:0]   program_counter,
    // bank for a set access flag and data memory read port
    input  wire logic [3:0]          bank_select_value,
    output logic      [11:0]         rd_addr,
    input  wire logic [7:0]          rd_data,
    // results
    output logic                     jump_load,
    output logic      [ADDR_W-1:0]   jump_target,
    output logic                     flush,
    output var rbs_pkg::rbs_dwrite_s dwrite,
    output var rbs_pkg::rbs_phase_e  phase
);

    // the doubled 11-bit offset needs 12 bits plus a sign bit above them
    if (ADDR_W < 13) begin : g_bad_width
        $error("ADDR_W below 13 cannot hold the doubled offset");
    end

    rbs_pkg::rbs_phase_e phase_q;
    rbs_pkg::rbs_phase_e phase_d;
    rbs_pkg::rbs_state_e state_q;
    logic [7:0]          rd_latch_q;
    logic [7:0]          set_mask;

    // phase and slot decode
    wire logic running  = (state_q == rbs_pkg::RBS_RUN);
    wire logic end_q4   = (phase_q == rbs_pkg::RBS_Q4);
    wire logic rd_phase = (phase_q == rbs_pkg::RBS_Q2);

    // opcode decode; a flushed slot decodes nothing
    wire logic is_branch = instr_valid && running
                           && (instr[15:11] == `RBS_JMP_TOP); // RQ1
    wire logic is_setbit = instr_valid && running
                           && (instr[15:12] == `RBS_SETB_TOP); // RQ5
    wire logic take_jump = end_q4 && is_branch;
    wire logic take_set  = end_q4 && is_setbit;

    // branch target
    wire logic [10:0] offs = instr[`RBS_OFF_MSB:`RBS_OFF_LSB]; // RQ1
    // sign-extend and double: word offset becomes byte displacement
    wire logic [ADDR_W-1:0] disp = {{(ADDR_W-12){offs[10]}},
                                    offs, 1'b0}; // RQ3
    // counter already passed the branch word, so no extra step here;
    // the sum wraps at the top of the address space on purpose
    wire logic [ADDR_W-1:0] target
        = ADDR_W'(program_counter + disp); // RQ2

    // register address and bit select of the bit set
    wire logic [3:0] bank = instr[`RBS_ACC_BIT] ? bank_select_value
                                                : `RBS_ACCESS_BANK; // RQ5
    wire logic [2:0] bitsel = instr[`RBS_BIT_MSB:`RBS_BIT_LSB];

    // one-hot mask of the bit to force
    genvar b;
    for (b = 0; b < 8; b++) begin : g_mask
        assign set_mask[b] = (bitsel == 3'(b)); // RQ5
    end
    wire logic [7:0] set_value = rd_latch_q | set_mask; // RQ5

    assign rd_addr = {bank, instr[`RBS_ADDR_MSB:0]};
    assign phase   = phase_q;
    assign flush   = !running;
    assign phase_d = rbs_pkg::rbs_phase_e'(2'(phase_q + 2'h1));

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_q <= rbs_pkg::RBS_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Q2 samples the register so that Q4 can write it back; the memory
    // must answer within the same cycle, there is no wait state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_latch_q <= 8'h00;
        end else if (rd_phase) begin
            rd_latch_q <= rd_data; // RQ5
        end
    end

    // a taken branch turns the next instruction cycle into a no-op,
    // since the word fetched behind it is the wrong one
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= rbs_pkg::RBS_RUN;
        end else if (end_q4) begin
            case (state_q)
                rbs_pkg::RBS_RUN: begin
                    if (is_branch) begin
                        state_q <= rbs_pkg::RBS_FLUSH; // RQ4
                    end
                end
                rbs_pkg::RBS_FLUSH: begin
                    state_q <= rbs_pkg::RBS_RUN; // RQ4
                end
                default: begin
                    state_q <= rbs_pkg::RBS_RUN;
                end
            endcase
        end
    end

    // target stands until the next branch
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            jump_load   <= 1'b0;
            jump_target <= ADDR_W'(`RBS_TGT_RESET);
        end else begin
            jump_load <= take_jump; // RQ4
            if (take_jump) begin
                jump_target <= target; // RQ3
            end
        end
    end

    // address and data stand until the next bit set
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dwrite <= '0;
        end else begin
            dwrite.we <= take_set; // RQ5
            if (take_set) begin
                dwrite.addr <= rd_addr;
                dwrite.data <= set_value; // RQ5
            end
        end
    end

    // branch checks
    AST_JUMP_TARGET: assert property (@(posedge ref_clk) disable iff (rst)
        take_jump |=> jump_load
            && jump_target == ADDR_W'($past(program_counter)
                + {{(ADDR_W-12){$past(instr[10])}},
                   $past(instr[10:0]), 1'b0})) // RQ3
        else $error("branch target wrong");
    AST_JUMP_TWO_CYCLES: assert property (@(posedge ref_clk)
        disable iff (rst) jump_load |-> flush ##4 !flush) // RQ4
        else $error("flush slot not one instruction cycle");
    AST_NO_JUMP_IN_FLUSH: assert property (@(posedge ref_clk)
        disable iff (rst) flush |=> !jump_load) // RQ4
        else $error("branch taken in flushed slot");
    AST_NO_WRITE_IN_FLUSH: assert property (@(posedge ref_clk)
        disable iff (rst) flush |=> !dwrite.we) // RQ4
        else $error("write in flushed slot");
    AST_OFF_NEG: assert property (@(posedge ref_clk) disable iff (rst)
        is_branch && offs[10]
            |-> ADDR_W'(program_counter - target)
                == {{(ADDR_W-12){1'b0}}, 11'(~offs + 11'h001),
                    1'b0}) // RQ1
        else $error("negative offset did not move backward");
    AST_OFF_POS: assert property (@(posedge ref_clk) disable iff (rst)
        is_branch && !offs[10]
            |-> ADDR_W'(target - program_counter)
                == {{(ADDR_W-11){1'b0}}, offs[9:0], 1'b0}) // RQ1
        else $error("positive offset did not move forward");
    AST_ZERO_OFF_BASE: assert property (@(posedge ref_clk)
        disable iff (rst)
        is_branch && offs == 11'h000 |-> target == program_counter) // RQ2
        else $error("zero offset must land after the branch");
    AST_LOAD_AT_Q1: assert property (@(posedge ref_clk) disable iff (rst)
        jump_load |-> phase_q == rbs_pkg::RBS_Q1) // RQ4
        else $error("counter load not at end of Q4");
    AST_TARGET_STANDS: assert property (@(posedge ref_clk)
        disable iff (rst) !jump_load |-> $stable(jump_target)) // RQ3
        else $error("target moved without a branch");

    // bit set checks
    AST_SET_BIT: assert property (@(posedge ref_clk) disable iff (rst)
        dwrite.we |-> dwrite.data[$past(bitsel)]) // RQ5
        else $error("selected bit not set");
    AST_SET_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
        dwrite.we |-> (dwrite.data | (8'h01 << $past(bitsel)))
            == ($past(rd_latch_q) | (8'h01 << $past(bitsel)))) // RQ5
        else $error("other bits changed");
    AST_SET_ACCESS_BANK: assert property (@(posedge ref_clk)
        disable iff (rst) is_setbit && !instr[`RBS_ACC_BIT]
            |-> rd_addr[11:8] == `RBS_ACCESS_BANK) // RQ5
        else $error("access bank not used");
    AST_SET_SELECT_BANK: assert property (@(posedge ref_clk)
        disable iff (rst) is_setbit && instr[`RBS_ACC_BIT]
            |-> rd_addr[11:8] == bank_select_value) // RQ5
        else $error("selected bank not used");
    AST_SET_ONE: assert property (@(posedge ref_clk) disable iff (rst)
        dwrite.we |=> !dwrite.we) // RQ5
        else $error("bit set wrote twice");
    AST_WRITE_AT_Q1: assert property (@(posedge ref_clk) disable iff (rst)
        dwrite.we |-> phase_q == rbs_pkg::RBS_Q1) // RQ5
        else $error("write not at end of Q4");

    // phase and reset checks
    AST_PHASE_STEP: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst) |-> phase_q == 2'($past(phase_q) + 2'h1)) // RQ4
        else $error("phase did not advance by one");
    AST_RESET_CLEARS: assert property (@(posedge ref_clk)
        rst |=> phase_q == rbs_pkg::RBS_Q1 && !jump_load
            && !dwrite.we && !flush) // RQ4
        else $error("reset left state behind");
endmodule
`default_nettype wire

// ===== pkg/rbs_map.svh
// offsets, field positions and timing counts of the branch and bit-set unit
`ifndef RBS_MAP_SVH
`define RBS_MAP_SVH
`define RBS_JMP_TOP      5'h1a
`define RBS_SETB_TOP     4'h8
`define RBS_OFF_LSB      0
`define RBS_OFF_MSB      10
`define RBS_ADDR_MSB     7
`define RBS_ACC_BIT      8
`define RBS_BIT_LSB      9
`define RBS_BIT_MSB      11
`define RBS_ACCESS_BANK  4'h0
`define RBS_WORD_STEP    21'h000002
`define RBS_TGT_RESET    21'h000000
`define RBS_JMP_CYCLES   2
`define RBS_Q_PHASES     4
`endif

// ===== pkg/rbs_pkg.sv
// types shared by the branch and bit-set unit
package rbs_pkg;
    typedef enum logic [1:0] {
        RBS_Q1 = 2'b00,
        RBS_Q2 = 2'b01,
        RBS_Q3 = 2'b10,
        RBS_Q4 = 2'b11
    } rbs_phase_e;
    typedef enum logic [0:0] {
        RBS_RUN   = 1'b0,
        RBS_FLUSH = 1'b1
    } rbs_state_e;
    typedef struct packed {
        logic        we;
        logic [11:0] addr;
        logic [7:0]  data;
    } rbs_dwrite_s;
endpackage

// ===== verification/rbs_mem_model.sv
// data memory model for the branch and bit-set unit
`timescale 1ns/1ps
`default_nettype none
module rbs_mem_model (
    // read port, answered at once
    input  wire logic [11:0] rd_addr,
    output logic      [7:0]  rd_data
);
    // value depends on bank and offset, so a wrong bank shows
    assign rd_data = rd_addr[7:0] ^ {rd_addr[11:8], 4'h6};
endmodule
`default_nettype wire

// ===== verification/rbs_exec_tb_top.sv
// self-checking bench for the branch and bit-set unit
`timescale 1ns/1ps
`default_nettype none
module rbs_exec_tb_top;
    logic                 ref_clk, rst, instr_valid, jump_load, flush;
    logic [15:0]          instr;
    logic [20:0]          program_counter, jump_target, exp_target;
    logic [3:0]           bank_select_value;
    logic [11:0]          rd_addr;
    logic [7:0]           rd_data;
    rbs_pkg::rbs_dwrite_s dwrite;
    rbs_pkg::rbs_phase_e  phase;
    int                   num_errors = 0, n_compared = 0, cycles = 0;
    rbs_exec u_rbs_exec (.ref_clk(ref_clk), .rst(rst),
        .instr_valid(instr_valid), .instr(instr),
        .program_counter(program_counter),
        .bank_select_value(bank_select_value), .rd_addr(rd_addr),
        .rd_data(rd_data), .jump_load(jump_load),
        .jump_target(jump_target), .flush(flush), .dwrite(dwrite),
        .phase(phase));
    rbs_mem_model u_rbs_mem_model (.rd_addr(rd_addr), .rd_data(rd_data));
    initial begin
        ref_clk = 0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // word held over all four phases of one instruction cycle
    task automatic issue(input logic [15:0] w);
        instr_valid = 1;
        instr = w;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic test_branch(input logic [10:0] n);
        issue({5'h1a, n});
        exp_target = program_counter + {{9{n[10]}}, n, 1'b0};
        chk(jump_load, 1);
        chk(jump_target, exp_target);
        chk({flush, phase}, 3'h4);
        issue(16'h8fff);
        chk({dwrite.we, jump_load, flush}, 0);
        chk(jump_target, exp_target);
        $display("branch test done");
    endtask
    task automatic test_bitset;
        for (int i = 0; i < 16; i++) begin
            logic [11:0] a;
            logic [7:0]  exp_d;
            a = {(i[3] ? bank_select_value : 4'h0), 8'h30 + 8'(i * 7)};
            exp_d = (a[7:0] ^ {a[11:8], 4'h6}) | (8'h01 << i[2:0]);
            issue({4'h8, 3'(i), i[3], a[7:0]});
            chk(dwrite.we, 1);
            chk(dwrite.addr, a);
            chk(dwrite.data, exp_d);
            chk({flush, jump_load}, 0);
        end
        $display("bit set test done");
    endtask
    // reset in the flushed slot of a branch, then a bit set at once
    task automatic test_reset;
        issue({5'h1a, 11'h010});
        rst = 1;
        instr_valid = 0;
        repeat (2) @(negedge ref_clk);
        chk({phase, flush, jump_load, dwrite.we}, 0);
        chk(jump_target, 0);
        rst = 0;
        issue({4'h8, 3'h5, 1'b0, 8'h42});
        chk(dwrite.we, 1);
        chk(dwrite.addr, 12'h042);
        chk(dwrite.data, (8'h42 ^ 8'h06) | 8'h20);
        $display("mid-run reset test done");
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            stop_test;
        end
    end
    initial begin
        rst = 1;
        instr_valid = 0;
        instr = 16'h0000;
        program_counter = 21'h000100;
        bank_select_value = 4'ha;
        repeat (5) @(negedge ref_clk);
        chk({phase, jump_load, flush, dwrite.we}, 0);
        rst = 0;
        test_branch(11'h400);
        test_branch(11'h000);
        program_counter = 21'h1ffff0;
        test_branch(11'h3ff);
        test_bitset;
        test_reset;
        stop_test;
    end
endmodule
`default_nettype wire
